// ==== core/hdma_chan_if.sv ====
// Signals between the unit top and one transfer channel
`timescale 1ns/1ps
interface hdma_chan_if;
  import hdma_pkg::*;
  logic        ldCw1, ldCw23, setCtl, clrCtl, setFlag, clrFlag, setMode, clrMode;
  logic [15:0] wdata;
  logic        cardFlag, grant;
  logic        memReq, ctl, flag, dirIn, busy;
  logic        cardStc, cardClf, cardClc, cardLoad;
  logic [5:0]  sc;
  logic [14:0] addr;
  logic [15:0] count;
  hdma_state_t state;
  modport chan (input  ldCw1, ldCw23, setCtl, clrCtl, setFlag, clrFlag, setMode, clrMode, wdata, cardFlag, grant,
                output memReq, ctl, flag, dirIn, busy, cardStc, cardClf, cardClc, cardLoad, sc, addr, count, state);
  modport ctrl (output ldCw1, ldCw23, setCtl, clrCtl, setFlag, clrFlag, setMode, clrMode, wdata, cardFlag, grant,
                input  memReq, ctl, flag, dirIn, busy, cardStc, cardClf, cardClc, cardLoad, sc, addr, count, state);
endinterface

// ==== core/hdma_channel.sv ====
// One transfer channel: control words, word sequencer and completion flag
`timescale 1ns/1ps
module hdma_channel
  import hdma_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Link to the unit top
  hdma_chan_if.chan bus
);

  logic        ctl_reg, flag_reg, mode_reg, optStc_reg, optClc_reg, dir_reg;
  logic [5:0]  sc_reg;
  logic [14:0] addr_reg;
  logic [15:0] count_reg;
  hdma_state_t state_reg, state_next;
  logic        active, lastWord;

  assign active   = ctl_reg & ~flag_reg;
  assign lastWord = (count_reg == COUNT_LAST); // [R24]

  always_comb begin
    case (state_reg)
      ST_IDLE:   state_next = (active && bus.cardFlag) ? ST_REQ : ST_IDLE; // [R17]
      ST_REQ:    state_next = !active ? ST_IDLE : (bus.grant ? ST_MEM : ST_REQ); // [R15]
      ST_MEM:    state_next = ST_XFER;
      ST_XFER:   state_next = lastWord ? ST_CLC : ST_SETTLE; // [R18]
      ST_SETTLE: state_next = ST_IDLE;
      ST_CLC:    state_next = ST_FIN; // [R19]
      ST_FIN:    state_next = ST_IDLE;
      default:   state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      ctl_reg   <= CTL_RST;
      flag_reg  <= FLAG_RST;
      mode_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      ctl_reg   <= bus.setCtl | (ctl_reg & ~bus.clrCtl);
      flag_reg  <= bus.setFlag | (state_reg == ST_FIN) | (flag_reg & ~bus.clrFlag); // [R15] [R19]
      mode_reg  <= bus.setMode | (mode_reg & ~bus.clrMode);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      optStc_reg <= 1'b0;
      optClc_reg <= 1'b0;
      sc_reg     <= 6'h00;
      dir_reg    <= 1'b0;
      addr_reg   <= 15'h0000;
      count_reg  <= WORD_RST;
    end else if (bus.ldCw1) begin
      optStc_reg <= bus.wdata[CW1_STC_BIT]; // [R20]
      optClc_reg <= bus.wdata[CW1_CLC_BIT]; // [R21]
      sc_reg     <= bus.wdata[5:0]; // [R06]
    end else if (bus.ldCw23 && !mode_reg) begin
      dir_reg    <= bus.wdata[CW2_DIR_BIT]; // [R22]
      addr_reg   <= bus.wdata[14:0];
    end else if (bus.ldCw23) begin
      count_reg  <= bus.wdata; // [R23] [R11]
    end else if (state_reg == ST_XFER) begin
      count_reg  <= count_reg + 16'h0001; // [R24]
      addr_reg   <= addr_reg + 15'h0001;
    end
  end

  assign bus.memReq   = (state_reg == ST_REQ) & active;
  assign bus.ctl      = ctl_reg;
  assign bus.flag     = flag_reg;
  assign bus.dirIn    = dir_reg;
  assign bus.sc       = sc_reg;
  assign bus.addr     = addr_reg;
  assign bus.count    = count_reg;
  assign bus.state    = state_reg;
  assign bus.busy     = (state_reg == ST_XFER) | (state_reg == ST_CLC);
  assign bus.cardClf  = (state_reg == ST_XFER); // [R18]
  assign bus.cardStc  = (state_reg == ST_XFER) & optStc_reg & ~(lastWord & dir_reg); // [R20]
  assign bus.cardLoad = (state_reg == ST_XFER) & ~dir_reg; // [R10]
  assign bus.cardClc  = (state_reg == ST_CLC) & optClc_reg; // [R21]

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_abort_stops_req: assert property (bus.setFlag |=> !bus.memReq) else $error("request after abort"); // [R15]
  a_grant_moves_word: assert property (bus.grant |=> state_reg == ST_MEM ##1 state_reg == ST_XFER)
    else $error("granted word did not move"); // [R17]
  a_count_steps: assert property (state_reg == ST_XFER |=> count_reg == $past(count_reg) + 16'h0001)
    else $error("count did not advance"); // [R24]
  a_end_sequence: assert property (state_reg == ST_XFER && lastWord |=> state_reg == ST_CLC ##1 flag_reg == 1'b0
    ##1 flag_reg == 1'b1 || $past(bus.clrFlag)) else $error("end sequence wrong"); // [R19]
  a_no_stc_last_in: assert property (state_reg == ST_XFER && lastWord && dir_reg |-> !bus.cardStc)
    else $error("set control on last input word"); // [R20]
  c_block_done: cover property (state_reg == ST_FIN);
  c_aborted: cover property (bus.setFlag && state_reg == ST_REQ);

endmodule

// ==== core/hdma_io_card.sv ====
// Built-in interface card: control bit, flag bit, buffer and priority link
`timescale 1ns/1ps
module hdma_io_card
  import hdma_pkg::*;
#(
  parameter logic [5:0] CARD_SC = SC_CARD_DEF
)(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Command bus
  input  wire logic [5:0]  cmdSc,
  input  wire logic        cmdStc,
  input  wire logic        cmdClc,
  input  wire logic        cmdStf,
  input  wire logic        cmdClf,
  input  wire logic        cmdLoad,
  input  wire logic [15:0] cmdData,
  // Interrupt chain
  input  wire logic        intEnable,
  input  wire logic        priIn,
  output      logic        priOut,
  output      logic        irq,
  // Status
  output      logic        flag,
  output      logic [15:0] buffer,
  // Peripheral side
  output      logic        devStart,
  output      logic [15:0] devOutData,
  input  wire logic        devDone,
  input  wire logic        devInValid,
  input  wire logic [15:0] devInData
);

  logic        ctl_reg, flag_reg, start_reg;
  logic [15:0] buf_reg;
  logic        hit;

  assign hit = (cmdSc == CARD_SC);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctl_reg   <= CTL_RST;
      flag_reg  <= FLAG_RST;
      start_reg <= 1'b0;
      buf_reg   <= WORD_RST;
    end else begin
      ctl_reg   <= (hit & cmdStc) | (ctl_reg & ~(hit & cmdClc)); // [R03]
      flag_reg  <= devDone | (hit & cmdStf) | (flag_reg & ~(hit & cmdClf));
      start_reg <= hit & cmdStc; // [R01]
      if (devDone && devInValid) begin
        buf_reg <= devInData;
      end else if (hit && cmdLoad) begin
        buf_reg <= cmdData;
      end
    end
  end

  assign irq        = flag_reg & ctl_reg & intEnable & priIn; // [R02]
  assign priOut     = priIn & ~(flag_reg & ctl_reg); // [R03]
  assign flag       = flag_reg;
  assign buffer     = buf_reg;
  assign devStart   = start_reg;
  assign devOutData = buf_reg; // [R01]

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_start_on_set: assert property (hit && cmdStc |=> devStart && ctl_reg) else $error("no start on set control"); // [R01]
  a_irq_gated: assert property (irq |-> ctl_reg && intEnable && priIn && flag_reg) else $error("ungated irq"); // [R02]
  a_clear_releases: assert property (hit && cmdClc && !cmdStc |=> priOut == priIn) else $error("chain held"); // [R03]

endmodule

// ==== core/hdma_pkg.sv ====
// Constants, types and timing for the two-channel word transfer unit
// How it works
// [R01] Card presents its buffer and pulses start whenever its control bit gets set.
// [R02] Card interrupt needs flag, control, interrupt enable and incoming priority.
// [R03] Clearing control passes priority downstream; reset leaves control clear, flag set.
// [R04] Software loads the card buffer, then sets control and clears flag.
// [R05] Skip test answers true exactly while the addressed flag is set.
// [R06] Two independent channels, each serving any select code.
// [R07] Channel 1 wins a memory slot over channel 2.
// [R08] Channels win a memory slot over the processor.
// [R09] Every memory slot may be taken, one word per slot.
// [R10] Whole 16-bit words move; word counter is 16 bits.
// [R11] Software loads direction, address, select code and count; hardware runs the block.
// [R12] Completion interrupts to location 6 or 7 when interrupts are enabled.
// [R13] Completion flag is tested at select code 6 or 7.
// [R14] Word count is read at select code 2 or 3.
// [R15] Software setting the completion flag aborts the block.
// [R16] Software starts the card once and preloads output data before enabling.
// [R17] A set card flag requests a slot and moves one word.
// [R18] After each word the card handshake restarts until the count runs out.
// [R19] At the end the card control is cleared, then completion is raised.
// [R20] Channel word bit 15 adds set-control to clear-flag, except last input word.
// [R21] Channel word bit 13 issues clear-control at the end of the block.
// [R22] Address word gives start address; bit 15 set means into memory.
// [R23] Length word is a negative count from -1 to -32768.
// [R24] Count and address advance per word; zero count ends the block.
package hdma_pkg;

  localparam int          CLK_HZ          = 50_000_000;
  localparam int          PEAK_WORDS_PS   = 1_020_400;
  localparam int          SLOT_CLKS       = CLK_HZ / PEAK_WORDS_PS;
  localparam logic [5:0]  SLOT_LAST       = 6'(SLOT_CLKS - 1);

  localparam logic [5:0]  SC_WC1          = 6'h02;
  localparam logic [5:0]  SC_CH1          = 6'h06;
  localparam logic [5:0]  SC_CARD_DEF     = 6'h0A;
  localparam logic [5:0]  SC_SPAN         = 6'h04;
  localparam logic [14:0] VEC_CH1         = 15'h0006;

  localparam int          CW1_STC_BIT     = 15;
  localparam int          CW1_CLC_BIT     = 13;
  localparam int          CW2_DIR_BIT     = 15;
  localparam logic [15:0] COUNT_LAST      = 16'hFFFF;

  localparam logic        FLAG_RST        = 1'b1;
  localparam logic        CTL_RST         = 1'b0;
  localparam logic [15:0] WORD_RST        = 16'h0000;

  typedef enum logic [2:0] {
    IO_STC = 3'h0,
    IO_CLC = 3'h1,
    IO_STF = 3'h2,
    IO_CLF = 3'h3,
    IO_SFS = 3'h4,
    IO_OTA = 3'h5,
    IO_LIA = 3'h6
  } hdma_op_t;

  typedef enum logic [6:0] {
    ST_IDLE   = 7'h01,
    ST_REQ    = 7'h02,
    ST_MEM    = 7'h04,
    ST_XFER   = 7'h08,
    ST_SETTLE = 7'h10,
    ST_CLC    = 7'h20,
    ST_FIN    = 7'h40
  } hdma_state_t;

endpackage

// ==== core/hdma_unit.sv ====
// Two-channel word transfer unit with cycle stealing and one built-in card
`timescale 1ns/1ps
module hdma_unit
  import hdma_pkg::*;
#(
  parameter logic [5:0] CARD_SC = SC_CARD_DEF
)(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Processor I/O instruction port
  input  wire logic        cpuIoStrobe,
  input  wire hdma_op_t    cpuIoOp,
  input  wire logic [5:0]  cpuIoSc,
  input  wire logic [15:0] cpuIoWdata,
  output      logic        cpuIoReady,
  output      logic        cpuSkip,
  output      logic [15:0] cpuIoRdata,
  // Interrupt system
  input  wire logic        intEnable,
  input  wire logic        priorityIn,
  output      logic        irqReq,
  output      logic [14:0] irqVector,
  // Memory slot arbitration and access
  input  wire logic        cpuMemReq,
  output      logic        cpuMemGnt,
  output      logic        memEn,
  output      logic        memWe,
  output      logic [14:0] memAddr,
  output      logic [15:0] memWdata,
  input  wire logic [15:0] memRdata,
  // I/O backplane
  output      logic [5:0]  ioRdSc,
  input  wire logic [15:0] ioInData,
  input  wire logic [63:0] flagBus,
  output      logic [5:0]  ioCmdSc,
  output      logic        ioStc,
  output      logic        ioClc,
  output      logic        ioStf,
  output      logic        ioClf,
  output      logic        ioLoad,
  output      logic [15:0] ioWdata,
  // Built-in card peripheral side
  output      logic        devStart,
  output      logic [15:0] devOutData,
  input  wire logic        devDone,
  input  wire logic        devInValid,
  input  wire logic [15:0] devInData
);

  function automatic logic opHit(input logic acc, input hdma_op_t op, input logic [5:0] sc,
                                 input hdma_op_t want, input logic [5:0] code);
    opHit = acc && (op == want) && (sc == code);
  endfunction

  hdma_chan_if chIf[2] ();

  logic        accept, grantAny, gSel, slotTick, dmaCode;
  logic [5:0]  slotCnt_reg;
  logic [1:0]  memReqV, grantV, busyV, flagV, ctlV, stcV, clfV, clcV, loadV, dirV;
  logic [5:0]  scV [2];
  logic [14:0] addrV [2];
  logic [15:0] countV [2];
  logic [63:0] flagVec;
  logic        cardFlag, cardIrq, cardPriOut;
  logic [15:0] cardBuf, inData;
  logic        own0, own1, cpuCmd;
  logic        irq0, irq1, irqNext;
  logic [14:0] vecNext;
  logic        skipSel;
  logic        memEn_reg, memWe_reg, irqReq_reg;
  logic [14:0] memAddr_reg, irqVector_reg;
  logic [15:0] memWdata_reg, cpuIoRdata_reg, ioWdata_reg;
  logic [5:0]  ioCmdSc_reg;
  logic        ioStc_reg, ioClc_reg, ioStf_reg, ioClf_reg, ioLoad_reg;
  logic [5:0]  cmdScNext;
  logic        stcNext, clcNext, clfNext, loadNext;
  logic [15:0] rdNext;

  assign accept  = cpuIoStrobe & cpuIoReady;
  assign dmaCode = (cpuIoSc >= SC_WC1) && (cpuIoSc < SC_CH1 + 6'h02);
  assign flagVec = flagBus | ({63'h0, cardFlag} << CARD_SC);

  for (genvar g = 0; g < 2; g++) begin : g_ch
    localparam logic [5:0] WC_SC = 6'(SC_WC1 + g);
    localparam logic [5:0] CH_SC = 6'(SC_CH1 + g);

    assign chIf[g].ldCw1    = opHit(accept, cpuIoOp, cpuIoSc, IO_OTA, CH_SC);
    assign chIf[g].setCtl   = opHit(accept, cpuIoOp, cpuIoSc, IO_STC, CH_SC);
    assign chIf[g].clrCtl   = opHit(accept, cpuIoOp, cpuIoSc, IO_CLC, CH_SC);
    assign chIf[g].setFlag  = opHit(accept, cpuIoOp, cpuIoSc, IO_STF, CH_SC); // [R15]
    assign chIf[g].clrFlag  = opHit(accept, cpuIoOp, cpuIoSc, IO_CLF, CH_SC);
    assign chIf[g].ldCw23   = opHit(accept, cpuIoOp, cpuIoSc, IO_OTA, WC_SC);
    assign chIf[g].setMode  = opHit(accept, cpuIoOp, cpuIoSc, IO_STC, WC_SC);
    assign chIf[g].clrMode  = opHit(accept, cpuIoOp, cpuIoSc, IO_CLC, WC_SC);
    assign chIf[g].wdata    = cpuIoWdata;
    assign chIf[g].cardFlag = flagVec[chIf[g].sc]; // [R17]
    assign chIf[g].grant    = grantV[g];

    assign memReqV[g] = chIf[g].memReq;
    assign busyV[g]   = chIf[g].busy;
    assign flagV[g]   = chIf[g].flag;
    assign ctlV[g]    = chIf[g].ctl;
    assign stcV[g]    = chIf[g].cardStc;
    assign clfV[g]    = chIf[g].cardClf;
    assign clcV[g]    = chIf[g].cardClc;
    assign loadV[g]   = chIf[g].cardLoad;
    assign dirV[g]    = chIf[g].dirIn;
    assign scV[g]     = chIf[g].sc;
    assign addrV[g]   = chIf[g].addr;
    assign countV[g]  = chIf[g].count;

    hdma_channel u_chan (
      .clk (clk),
      .rst (rst),
      .bus (chIf[g])
    ); // [R06]
  end

  // Memory slot timer and arbitration
  assign slotTick  = (slotCnt_reg == 6'h00);
  assign grantV[0] = slotTick & memReqV[0]; // [R07]
  assign grantV[1] = slotTick & memReqV[1] & ~memReqV[0]; // [R07]
  assign cpuMemGnt = slotTick & cpuMemReq & ~memReqV[0] & ~memReqV[1]; // [R08]
  assign grantAny  = grantV[0] | grantV[1];
  assign gSel      = ~grantV[0];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      slotCnt_reg <= 6'h00;
    end else begin
      slotCnt_reg <= slotTick ? SLOT_LAST : slotCnt_reg - 6'h01; // [R09]
    end
  end

  // Data path into and out of memory
  assign ioRdSc     = grantAny ? scV[gSel] : cpuIoSc;
  assign inData     = (ioRdSc == CARD_SC) ? cardBuf : ioInData;
  assign cpuIoReady = ~grantAny & ~busyV[0] & ~busyV[1];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      memEn_reg    <= 1'b0;
      memWe_reg    <= 1'b0;
      memAddr_reg  <= 15'h0000;
      memWdata_reg <= WORD_RST;
    end else begin
      memEn_reg <= grantAny; // [R17]
      memWe_reg <= grantAny & dirV[gSel]; // [R22]
      if (grantAny) begin
        memAddr_reg  <= addrV[gSel];
        memWdata_reg <= inData; // [R10]
      end
    end
  end

  // Backplane command bus: channels first, then the processor
  assign own0      = busyV[0];
  assign own1      = busyV[1] & ~busyV[0];
  assign cpuCmd    = accept & ~dmaCode;
  assign cmdScNext = own0 ? scV[0] : (own1 ? scV[1] : cpuIoSc);
  assign stcNext   = own0 ? stcV[0] : (own1 ? stcV[1] : cpuCmd & (cpuIoOp == IO_STC)); // [R18]
  assign clfNext   = own0 ? clfV[0] : (own1 ? clfV[1] : cpuCmd & (cpuIoOp == IO_CLF)); // [R18]
  assign clcNext   = own0 ? clcV[0] : (own1 ? clcV[1] : cpuCmd & (cpuIoOp == IO_CLC)); // [R21]
  assign loadNext  = own0 ? loadV[0] : (own1 ? loadV[1] : cpuCmd & (cpuIoOp == IO_OTA)); // [R04]

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ioCmdSc_reg <= 6'h00;
      ioStc_reg   <= 1'b0;
      ioClc_reg   <= 1'b0;
      ioStf_reg   <= 1'b0;
      ioClf_reg   <= 1'b0;
      ioLoad_reg  <= 1'b0;
      ioWdata_reg <= WORD_RST;
    end else begin
      ioCmdSc_reg <= cmdScNext;
      ioStc_reg   <= stcNext;
      ioClc_reg   <= clcNext;
      ioStf_reg   <= ~own0 & ~own1 & cpuCmd & (cpuIoOp == IO_STF);
      ioClf_reg   <= clfNext;
      ioLoad_reg  <= loadNext;
      ioWdata_reg <= (own0 | own1) ? memRdata : cpuIoWdata;
    end
  end

  // Processor reads and skip test
  assign rdNext  = (cpuIoSc == SC_WC1) ? countV[0] :
                   (cpuIoSc == SC_WC1 + 6'h01) ? countV[1] : inData; // [R14]
  assign skipSel = (cpuIoSc == SC_CH1) ? flagV[0] :
                   (cpuIoSc == SC_CH1 + 6'h01) ? flagV[1] : flagVec[cpuIoSc]; // [R13]
  assign cpuSkip = cpuIoStrobe & (cpuIoOp == IO_SFS) & skipSel; // [R05]

  // Interrupt priority: channel 1, channel 2, then the built-in card
  assign irq0    = flagV[0] & ctlV[0] & intEnable & priorityIn; // [R12]
  assign irq1    = flagV[1] & ctlV[1] & intEnable & priorityIn & ~(flagV[0] & ctlV[0]); // [R12]
  assign irqNext = irq0 | irq1 | cardIrq;
  assign vecNext = irq0 ? VEC_CH1 : (irq1 ? VEC_CH1 + 15'h0001 : {9'h000, CARD_SC});

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cpuIoRdata_reg <= WORD_RST;
      irqReq_reg     <= 1'b0;
      irqVector_reg  <= 15'h0000;
    end else begin
      if (accept && cpuIoOp == IO_LIA) begin
        cpuIoRdata_reg <= rdNext;
      end
      irqReq_reg    <= irqNext;
      irqVector_reg <= irqNext ? vecNext : irqVector_reg;
    end
  end

  hdma_io_card #(
    .CARD_SC (CARD_SC)
  ) u_card (
    .clk        (clk),
    .rst        (rst),
    .cmdSc      (ioCmdSc_reg),
    .cmdStc     (ioStc_reg),
    .cmdClc     (ioClc_reg),
    .cmdStf     (ioStf_reg),
    .cmdClf     (ioClf_reg),
    .cmdLoad    (ioLoad_reg),
    .cmdData    (ioWdata_reg),
    .intEnable  (intEnable),
    .priIn      (priorityIn & ~(flagV[0] & ctlV[0]) & ~(flagV[1] & ctlV[1])),
    .priOut     (cardPriOut),
    .irq        (cardIrq),
    .flag       (cardFlag),
    .buffer     (cardBuf),
    .devStart   (devStart),
    .devOutData (devOutData),
    .devDone    (devDone),
    .devInValid (devInValid),
    .devInData  (devInData)
  );

  assign cpuIoRdata = cpuIoRdata_reg;
  assign irqReq     = irqReq_reg;
  assign irqVector  = irqVector_reg;
  assign memEn      = memEn_reg;
  assign memWe      = memWe_reg;
  assign memAddr    = memAddr_reg;
  assign memWdata   = memWdata_reg;
  assign ioCmdSc    = ioCmdSc_reg;
  assign ioStc      = ioStc_reg;
  assign ioClc      = ioClc_reg;
  assign ioStf      = ioStf_reg;
  assign ioClf      = ioClf_reg;
  assign ioLoad     = ioLoad_reg;
  assign ioWdata    = ioWdata_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_ch1_first: assert property (slotTick && memReqV[0] && memReqV[1] |-> grantV[0] && !grantV[1])
    else $error("channel 2 beat channel 1"); // [R07]
  a_dma_over_cpu: assert property (cpuMemGnt |-> !memReqV[0] && !memReqV[1])
    else $error("processor beat a channel"); // [R08]
  a_slot_period: assert property (slotTick |-> ##49 slotTick) else $error("slot period wrong"); // [R09]
  a_grant_mem: assert property (grantAny |=> memEn && memAddr == $past(addrV[gSel]))
    else $error("granted word not issued"); // [R17]
  a_done_vector: assert property (irq0 |=> irqReq && irqVector == VEC_CH1) else $error("wrong vector"); // [R12]
  c_both_request: cover property (slotTick && memReqV[0] && memReqV[1]);
  c_cpu_slot: cover property (cpuMemGnt);

endmodule

// ==== verification/hdma_periph_model.sv ====
// Peripheral behind the built-in card: answers each start after a short or long delay
`timescale 1ns/1ps
module hdma_periph_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Card side
  input  wire logic        devStart,
  input  wire logic [15:0] devOutData,
  output      logic        devDone,
  output      logic        devInValid,
  output      logic [15:0] devInData,
  // Bench control
  input  wire logic        slow,
  input  wire logic [15:0] nextWord,
  output      logic [15:0] lastOut
);
  int waitCnt;
  // Input data is only meaningful with done; it inverts every cycle without done
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      waitCnt <= 0;
      devDone <= 1'b0;
      devInData <= 16'h0000;
      lastOut <= 16'h0000;
    end else begin
      devDone <= (waitCnt == 1);
      devInData <= (waitCnt == 1) ? nextWord : ~devInData;
      if (devStart) begin
        lastOut <= devOutData;
        waitCnt <= slow ? 9 : 2;
      end else if (waitCnt != 0) begin
        waitCnt <= waitCnt - 1;
      end
    end
  end
  assign devInValid = devDone;
endmodule

// ==== verification/tb_top.sv ====
// Self-checking bench for the two-channel word transfer unit
`timescale 1ns/1ps
module tb_top;
  import hdma_pkg::*;
  localparam logic [5:0] CARD = SC_CARD_DEF;
  logic        clk, rst, cpuIoStrobe, cpuIoReady, cpuSkip, intEnable, priorityIn, irqReq, cpuMemReq, cpuMemGnt;
  logic        memEn, memWe, ioStc, ioClc, ioStf, ioClf, ioLoad, devStart, devDone, devInValid, slow, skp, clcSeen;
  logic [5:0]  cpuIoSc, ioRdSc, ioCmdSc;
  logic [14:0] irqVector, memAddr, expAddr, a;
  logic [15:0] cpuIoWdata, cpuIoRdata, memWdata, memRdata, ioInData, ioWdata, devOutData, devInData;
  logic [15:0] nextWord, lastOut, d;
  logic [63:0] flagBus;
  logic [31:0] rs;
  logic [15:0] inQ[$];
  hdma_op_t    cpuIoOp;
  int          failures, num_checks, words, n;

  hdma_unit dut (.*);
  hdma_periph_model periph (.*);

  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One I/O instruction; strobe stays up so instructions can follow back to back
  task automatic io(input hdma_op_t op, input logic [5:0] sc, input logic [15:0] wd);
    int k;
    k = 0;
    cpuIoStrobe = 1'b1;
    cpuIoOp = op;
    cpuIoSc = sc;
    cpuIoWdata = wd;
    // Ready and skip are read mid-cycle, where they hold the value the taking edge will see
    @(negedge clk);
    while (cpuIoReady !== 1'b1 && k < 100) begin
      k++;
      @(negedge clk);
    end
    if (k == 100) failures++;
    skp = cpuSkip;
    @(posedge clk);
    #1;
  endtask

  task automatic poll(input logic [5:0] sc);
    n = 0;
    do begin
      io(IO_SFS, sc, 16'h0000);
      n++;
    end while (skp !== 1'b1 && n < 1000);
    cpuIoStrobe = 1'b0;
  endtask

  task automatic summarize();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    #1;
    rs = xs(rs);
    cpuMemReq = rs[0];
    nextWord = rs[23:8];
  end

  always @(posedge clk) if (memEn) memRdata <= {1'b0, memAddr};

  // Reference: every word written into memory is the next peripheral word at the next address
  always @(posedge clk) begin
    if (devDone) inQ.push_back(devInData);
    if (ioClc && ioCmdSc == CARD) clcSeen = 1'b1;
    if (memEn && memWe) begin
      check(memWdata, inQ.size() != 0 ? inQ.pop_front() : 16'hDEAD, "word");
      check({1'b0, memAddr}, {1'b0, expAddr}, "address");
      expAddr++;
      words++;
    end
  end

  initial begin
    #(20 * 20000);
    failures++;
    summarize();
  end

  initial begin
    rs = 32'h00002D5E;
    {rst, intEnable, priorityIn, slow} = 4'b1110;
    {cpuIoStrobe, cpuIoSc, cpuIoWdata} = '0;
    cpuIoOp = IO_STC;
    {cpuMemReq, memRdata, ioInData, flagBus, nextWord, clcSeen} = '0;
    {failures, num_checks, words} = '0;
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    io(IO_SFS, SC_CH1, 16'h0000);
    check({15'h0000, skp}, 16'h0001, "chan flag at reset");
    io(IO_SFS, CARD, 16'h0000);
    check({15'h0000, skp}, 16'h0001, "card flag at reset");
    check({15'h0000, irqReq}, 16'h0000, "irq at reset");
    $display("test reset done");
    slow = 1'b1;
    d = rs[15:0];
    io(IO_OTA, CARD, d);
    io(IO_STC, CARD, 16'h0000);
    io(IO_CLF, CARD, 16'h0000);
    // Card commands reach the card one cycle after they are taken
    cpuIoStrobe = 1'b0;
    @(posedge clk);
    #1 io(IO_SFS, CARD, 16'h0000);
    check({15'h0000, skp}, 16'h0000, "no skip while busy");
    poll(CARD);
    check({15'h0000, skp}, 16'h0001, "skip on flag");
    check(lastOut, d, "card output");
    repeat (2) @(posedge clk);
    #1 check({irqReq, irqVector}, {1'b1, 9'h000, CARD}, "card interrupt");
    io(IO_CLC, CARD, 16'h0000);
    cpuIoStrobe = 1'b0;
    repeat (4) @(posedge clk);
    #1 check({15'h0000, irqReq}, 16'h0000, "irq after clear control");
    $display("test programmed output done");
    slow = 1'b0;
    a = {1'b0, rs[13:0]};
    expAddr = a;
    // Drop device words and end commands left from the programmed transfer
    inQ.delete();
    clcSeen = 1'b0;
    io(IO_OTA, SC_CH1, 16'hA000 | {10'h000, CARD});
    io(IO_CLC, SC_WC1, 16'h0000);
    io(IO_OTA, SC_WC1, {1'b1, a});
    io(IO_STC, SC_WC1, 16'h0000);
    io(IO_OTA, SC_WC1, 16'hFFFD);
    io(IO_STC, CARD, 16'h0000);
    io(IO_CLF, CARD, 16'h0000);
    io(IO_STC, SC_CH1, 16'h0000);
    io(IO_CLF, SC_CH1, 16'h0000);
    poll(SC_CH1);
    check({15'h0000, skp}, 16'h0001, "completion flag");
    check(16'(words), 16'h0003, "word count moved");
    check({15'h0000, clcSeen}, 16'h0001, "clear control at end");
    repeat (3) @(posedge clk);
    #1 check({irqReq, irqVector}, {1'b1, VEC_CH1}, "completion interrupt");
    io(IO_LIA, SC_WC1, 16'h0000);
    check(cpuIoRdata, 16'h0000, "count read");
    $display("test block input done");
    io(IO_OTA, 6'h07, 16'h0011);
    io(IO_CLC, 6'h03, 16'h0000);
    io(IO_OTA, 6'h03, 16'h0100);
    io(IO_STC, 6'h03, 16'h0000);
    io(IO_OTA, 6'h03, 16'hFFFB);
    io(IO_STC, 6'h07, 16'h0000);
    io(IO_CLF, 6'h07, 16'h0000);
    io(IO_SFS, 6'h07, 16'h0000);
    check({15'h0000, skp}, 16'h0000, "chan 2 active");
    io(IO_STF, 6'h07, 16'h0000);
    io(IO_SFS, 6'h07, 16'h0000);
    check({15'h0000, skp}, 16'h0001, "abort sets flag");
    io(IO_LIA, 6'h03, 16'h0000);
    check(cpuIoRdata, 16'hFFFB, "count after abort");
    cpuIoStrobe = 1'b0;
    repeat (60) @(posedge clk);
    #1 check(16'(words), 16'h0003, "no words after abort");
    $display("test abort done");
    summarize();
  end
endmodule
